// ### acmp_pkg.sv
// Package with constants and types for the comparator control block.
package acmp_pkg;

  localparam int ACMP_INSTANCES = 3;
  localparam int ACMP_SYNC_STAGES = 3;

  // Edge selection codes.
  localparam logic [1:0] ACMP_EDGE_BOTH = 2'h0;
  localparam logic [1:0] ACMP_EDGE_RSVD = 2'h1;
  localparam logic [1:0] ACMP_EDGE_FALL = 2'h2;
  localparam logic [1:0] ACMP_EDGE_RISE = 2'h3;

  // Hysteresis codes: off, 10 mV, 25 mV, 50 mV.
  localparam logic [1:0] ACMP_HYS_OFF = 2'h0;
  localparam logic [1:0] ACMP_HYS_10MV = 2'h1;
  localparam logic [1:0] ACMP_HYS_25MV = 2'h2;
  localparam logic [1:0] ACMP_HYS_50MV = 2'h3;

  // Negative input codes.
  localparam logic [1:0] ACMP_NEG_PIN0 = 2'h0;
  localparam logic [1:0] ACMP_NEG_PIN1 = 2'h1;
  localparam logic [1:0] ACMP_NEG_VREF = 2'h2;
  localparam logic [1:0] ACMP_NEG_CONV = 2'h3;

  // Settling times for software, in nanoseconds, and derived cycle counts at 50 MHz.
  localparam int ACMP_CLK_NS = 20;
  localparam int ACMP_STARTUP_NS = 2500;
  localparam int ACMP_VREF_NS = 60000;
  localparam int ACMP_STARTUP_CYC = (ACMP_STARTUP_NS + ACMP_CLK_NS - 1) / ACMP_CLK_NS;
  localparam int ACMP_VREF_CYC = (ACMP_VREF_NS + ACMP_CLK_NS - 1) / ACMP_CLK_NS;

  // Reset values.
  localparam logic ACMP_RST_BIT = 1'b0;

  typedef enum logic [3:0] {
    ACMP_SLP_ACTIVE = 4'h1,
    ACMP_SLP_IDLE = 4'h2,
    ACMP_SLP_STANDBY = 4'h4,
    ACMP_SLP_PDOWN = 4'h8
  } acmp_sleep_t;

  typedef struct packed {
    logic enable;
    logic keepRunningInStandby;
    logic padOutputEnable;
    logic [1:0] edgeSelect;
    logic [1:0] hysteresisSelect;
    logic invert;
    logic [1:0] positiveInputSelect;
    logic [1:0] negativeInputSelect;
    logic irqEnable;
  } acmp_cfg_t;

  typedef struct packed {
    logic state;
    logic irqFlag;
    logic irq;
    logic eventOut;
    logic padOut;
    logic padOe;
  } acmp_stat_t;

  typedef struct packed {
    logic analogEnable;
    logic [1:0] hysteresis;
    logic [1:0] posSelect;
    logic [1:0] negSelect;
  } acmp_ana_t;

endpackage

// ### acmp_channel.sv
// One comparator channel: synchroniser, edge detection, flag, request and outputs.
`timescale 1ns/1ps
module acmp_channel
  import acmp_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire acmp_cfg_t cfg,
  input wire acmp_sleep_t sleepMode,
  input wire logic flagClear,
  input wire logic rawCompare,
  output acmp_stat_t stat,
  output acmp_ana_t ana
);

  typedef struct packed {
    logic [ACMP_SYNC_STAGES-1:0] sync;
    logic prevLevel;
    logic primed;
    acmp_stat_t stat;
    acmp_ana_t ana;
  } acmp_chan_state_t;

  acmp_chan_state_t s_q;
  acmp_chan_state_t s_d;

  function automatic logic edgeMatch(input logic [1:0] sel, input logic prev, input logic cur);
    logic rise;
    logic fall;
    rise = cur & ~prev;
    fall = prev & ~cur;
    case (sel)
      ACMP_EDGE_BOTH: edgeMatch = rise | fall;
      ACMP_EDGE_FALL: edgeMatch = fall;
      ACMP_EDGE_RISE: edgeMatch = rise;
      default: edgeMatch = 1'b0;
    endcase
  endfunction

  logic running;
  logic statusLive;
  logic level;
  logic hit;

  always_comb begin
    s_d = s_q;
    // Standby runs only with keep-running; power down always stops.
    case (sleepMode)
      ACMP_SLP_ACTIVE, ACMP_SLP_IDLE: running = cfg.enable;
      ACMP_SLP_STANDBY: running = cfg.enable & cfg.keepRunningInStandby;
      ACMP_SLP_PDOWN: running = 1'b0;
      default: running = cfg.enable;
    endcase
    statusLive = running & (sleepMode != ACMP_SLP_STANDBY);
    s_d.ana.analogEnable = running;
    s_d.ana.hysteresis = cfg.hysteresisSelect;
    s_d.ana.posSelect = cfg.positiveInputSelect;
    s_d.ana.negSelect = cfg.negativeInputSelect;
    // Inversion applies before every consumer, including status and edges.
    s_d.sync = {s_q.sync[ACMP_SYNC_STAGES-2:0], rawCompare ^ cfg.invert};
    level = s_q.sync[ACMP_SYNC_STAGES-1];
    hit = running & s_q.primed & edgeMatch(cfg.edgeSelect, s_q.prevLevel, level);
    s_d.prevLevel = level;
    s_d.primed = running;
    s_d.stat.eventOut = running & level;
    s_d.stat.padOut = running & level;
    s_d.stat.padOe = running & cfg.padOutputEnable;
    if (statusLive) begin
      s_d.stat.state = level;
    end
    // Outside standby, a new edge in the clearing cycle keeps the flag set.
    if (hit & statusLive) begin
      s_d.stat.irqFlag = 1'b1;
    end else if (flagClear) begin
      s_d.stat.irqFlag = 1'b0;
    end
    s_d.stat.irq = cfg.irqEnable & s_d.stat.irqFlag;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign stat = s_q.stat;
  assign ana = s_q.ana;

  a_irq_follows_flag: assert property (@(posedge mclk) disable iff (!resetn)
    stat.irq == (stat.irqFlag & $past(cfg.irqEnable))) else $error("irq not flag and enable");
  a_flag_holds: assert property (@(posedge mclk) disable iff (!resetn)
    $fell(stat.irqFlag) |-> $past(flagClear)) else $error("flag fell without clear");
  a_pdown_quiet: assert property (@(posedge mclk) disable iff (!resetn)
    sleepMode == ACMP_SLP_PDOWN |=> !stat.padOe && !ana.analogEnable) else $error("power down active");
  a_standby_frozen: assert property (@(posedge mclk) disable iff (!resetn)
    sleepMode == ACMP_SLP_STANDBY |=> $stable(stat.state) && !$rose(stat.irqFlag)) else $error("standby status moved");
  a_state_delay: assert property (@(posedge mclk) disable iff (!resetn)
    (sleepMode == ACMP_SLP_ACTIVE && cfg.enable)[*5] |-> stat.state == $past(s_q.sync[0], 3)) else $error("state delay wrong");
  a_event_level: assert property (@(posedge mclk) disable iff (!resetn)
    stat.eventOut |-> $past(running)) else $error("event while stopped");
  a_rise_sets: assert property (@(posedge mclk) disable iff (!resetn)
    hit && statusLive |=> stat.irqFlag) else $error("edge lost");
  a_rsvd_edge: assert property (@(posedge mclk) disable iff (!resetn)
    cfg.edgeSelect == ACMP_EDGE_RSVD |=> !$rose(stat.irqFlag)) else $error("reserved edge fired");

endmodule // acmp_channel

// ### acmp_top.sv
// Three-instance comparator control: configuration ports, channels and outputs.
`timescale 1ns/1ps
module acmp_top
  import acmp_pkg::*;
#(
  parameter int INSTANCES = ACMP_INSTANCES
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire acmp_cfg_t [INSTANCES-1:0] cfg,
  input wire acmp_sleep_t sleepMode,
  input wire logic debugHalt,
  input wire logic [INSTANCES-1:0] flagClearW1c,
  input wire logic [INSTANCES-1:0] rawCompare,
  output acmp_stat_t [INSTANCES-1:0] stat,
  output acmp_ana_t [INSTANCES-1:0] ana
);

  // Refused while the hierarchy is built, so a bad count never reaches a run.
  if (INSTANCES < 1) begin : g_bad_instances
    $error("INSTANCES must be at least one");
  end

  // The analog core resolves the voltage comparison; rawCompare is that result.
  // Debug halt is accepted but deliberately not used by any logic.
  for (genvar i = 0; i < INSTANCES; i++) begin : g_ch
    acmp_channel u_ch (
      .mclk(mclk),
      .resetn(resetn),
      .cfg(cfg[i]),
      .sleepMode(sleepMode),
      .flagClear(flagClearW1c[i]),
      .rawCompare(rawCompare[i]),
      .stat(stat[i]),
      .ana(ana[i])
    );
  end

endmodule // acmp_top

// ### acmp_analog_model.sv
// Behavioural analog front end that compares the selected voltages of each channel.
`timescale 1ns/1ps
module acmp_analog_model
  import acmp_pkg::*;
(
  input wire acmp_ana_t [2:0] ana,
  input wire logic [2:0][3:0][11:0] posMv,
  input wire logic [2:0][3:0][11:0] negMv,
  output logic [2:0] rawCompare
);
  // A powered-down front end gives no valid result, so it is held low.
  // Hysteresis is not modelled because the input steps are far apart.
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      rawCompare[i] = ana[i].analogEnable &&
        (posMv[i][ana[i].posSelect] > negMv[i][ana[i].negSelect]);
    end
  end
endmodule // acmp_analog_model

// ### tb_analog_comparator_control.sv
// Random and corner-case bench for the three-channel comparator control.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb_analog_comparator_control;
  import acmp_pkg::*;
  logic mclk = 0, resetn = 0, debugHalt = 0;
  acmp_cfg_t [2:0] cfg = '0;
  acmp_sleep_t sleepMode = ACMP_SLP_ACTIVE;
  logic [2:0] flagClearW1c = '0, rawCompare;
  logic [2:0][3:0][11:0] posMv = '0, negMv = '0;
  acmp_stat_t [2:0] stat;
  acmp_ana_t [2:0] ana;
  int mismatches = 0, checks = 0;
  logic [31:0] seed = 32'hb5a0716d;
  always #10 mclk = ~mclk;
  acmp_top i_dut (.mclk(mclk), .resetn(resetn), .cfg(cfg), .sleepMode(sleepMode),
    .debugHalt(debugHalt), .flagClearW1c(flagClearW1c), .rawCompare(rawCompare),
    .stat(stat), .ana(ana));
  acmp_analog_model i_ana (.ana(ana), .posMv(posMv), .negMv(negMv), .rawCompare(rawCompare));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  function automatic logic edgeHit(input logic [1:0] code, input logic rise);
    return code == ACMP_EDGE_BOTH || code == (rise ? ACMP_EDGE_RISE : ACMP_EDGE_FALL);
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  task automatic clearFlag(input int i);
    flagClearW1c[i] = 1'b1;
    tick(1);
    flagClearW1c[i] = 1'b0;
  endtask
  task automatic end_of_test();
    if (mismatches == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    int i;
    logic inv, pd, stby, run, upd, res, flg;
    acmp_sleep_t sm;
    tick(10);
    resetn = 1'b1;
    tick(1);
    `CHK(stat, '0)
    // Inputs first, then pad drive, then enable, in the order software must keep.
    for (int c = 0; c < 3; c++) begin
      cfg[c].negativeInputSelect = ACMP_NEG_VREF;
      tick(1);
      cfg[c].padOutputEnable = 1'b1;
      tick(1);
      cfg[c].enable = 1'b1;
      tick(1);
    end
    // The shared reference takes far longer than the comparator to settle.
    tick(ACMP_VREF_CYC);
    for (int c = 0; c < 3; c++) begin
      `CHK({stat[c].padOe, ana[c].analogEnable, ana[c].negSelect}, {2'b11, ACMP_NEG_VREF})
    end
    for (int n = 0; n < 48; n++) begin
      i = n % 3;
      seed = lfsr(seed);
      cfg[i] = acmp_cfg_t'(seed[12:0]);
      cfg[i].enable = 1'b1;
      cfg[i].edgeSelect = 2'(n / 3);
      sm = acmp_sleep_t'(4'h1 << seed[14:13]);
      debugHalt = seed[15];
      sleepMode = ACMP_SLP_ACTIVE;
      inv = cfg[i].invert;
      // Only the selected negative pin sits above the positive level, so a wrong select shows.
      for (int p = 0; p < 4; p++) begin
        negMv[i][p] = (p == cfg[i].negativeInputSelect) ? 12'h0c8 : 12'h000;
        posMv[i][p] = 12'h064;
      end
      // Settle first so an edge caused by the new inversion is cleared away.
      tick(ACMP_STARTUP_CYC);
      clearFlag(i);
      sleepMode = sm;
      tick(3);
      pd = sm == ACMP_SLP_PDOWN;
      stby = sm == ACMP_SLP_STANDBY;
      run = !pd && (!stby || cfg[i].keepRunningInStandby);
      upd = !pd && !stby;
      flg = 1'b0;
      for (int k = 0; k < 2; k++) begin
        res = (k == 0) ^ inv;
        for (int p = 0; p < 4; p++) begin
          posMv[i][p] = (k == 0 && p == cfg[i].positiveInputSelect) ? 12'h12c : 12'h064;
        end
        tick(8);
        flg |= upd && edgeHit(cfg[i].edgeSelect, res);
        `CHK(stat[i].irqFlag, flg)
        `CHK(stat[i].irq, flg & cfg[i].irqEnable)
        `CHK(stat[i].eventOut, run & res)
        `CHK(stat[i].padOut, run & res)
        `CHK(stat[i].padOe, run & cfg[i].padOutputEnable)
        `CHK(ana[i].analogEnable, run)
        `CHK(ana[i].hysteresis, cfg[i].hysteresisSelect)
        `CHK({ana[i].posSelect, ana[i].negSelect}, cfg[i][4:1])
        `CHK(stat[i].state, upd ? res : inv)
      end
      clearFlag(i);
      tick(1);
      `CHK(stat[i].irqFlag, 1'b0)
    end
    end_of_test();
  end
  initial begin
    #400000;
    mismatches++;
    end_of_test();
  end
endmodule // tb_analog_comparator_control
